/* hdl/pbcu_regs.svh */
`ifndef PBCU_REGS_SVH
`define PBCU_REGS_SVH

// Command opcodes
`define PBCU_OP_SEC_READ 8'h77
`define PBCU_OP_COPY_B1 8'h53
`define PBCU_OP_COPY_B2 8'h55
`define PBCU_OP_CMP_B1 8'h60
`define PBCU_OP_CMP_B2 8'h61
`define PBCU_OP_RW_B1 8'h58
`define PBCU_OP_RW_B2 8'h59

// Frame layout: opcode plus three address or dummy bytes
`define PBCU_CMD_BITS 6'h20
`define PBCU_LAST_CMD_BIT 6'h1F
`define PBCU_PAGE_W 12
`define PBCU_PG528_LSB 10
`define PBCU_PG512_LSB 9

// Security area
`define PBCU_SEC_BYTES 8'h80
`define PBCU_SEC_AW 7

// Status byte fields
`define PBCU_ST_READY_BIT 7
`define PBCU_ST_COMP_BIT 6
`define PBCU_ST_DENSITY 4'hB

// Timing, times in ns; longest times round down to whole cycles
`define PBCU_CLK_PERIOD_NS 100
`define PBCU_PAGE_COPY_TIME_NS 200000
`define PBCU_PAGE_COMPARE_TIME_NS 200000
`define PBCU_PAGE_REFRESH_TIME_NS 25000000
`define PBCU_PAGE_COPY_CYC (`PBCU_PAGE_COPY_TIME_NS / `PBCU_CLK_PERIOD_NS)
`define PBCU_PAGE_COMPARE_CYC (`PBCU_PAGE_COMPARE_TIME_NS / `PBCU_CLK_PERIOD_NS)
`define PBCU_PAGE_REFRESH_CYC (`PBCU_PAGE_REFRESH_TIME_NS / `PBCU_CLK_PERIOD_NS)

`endif

/* hdl/pbcu_pkg.sv */
package pbcu_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COPY,
    ST_CMP,
    ST_RW_COPY,
    ST_RW_PROG
  } pbcu_state_e;

  // Operation requested from the array engine
  typedef enum logic [1:0] {
    ARR_COPY,
    ARR_COMPARE,
    ARR_PROGRAM
  } pbcu_arr_op_e;

  // Kind of internal command
  typedef enum logic [1:0] {
    KIND_COPY,
    KIND_CMP,
    KIND_RW
  } pbcu_kind_e;

  // Decoded opcode
  typedef struct packed {
    logic valid;
    pbcu_kind_e kind;
    logic bsel;
  } pbcu_cmd_s;

endpackage

/* hdl/pbcu_secmem.sv */
`timescale 1ns/1ps
// Security area storage; read data come out of a register
module pbcu_secmem #(
  parameter int unsigned DEPTH = 128,
  parameter int unsigned AW = 7,
  parameter logic [7:0] SEED = 8'h5A // Arbitrary fill pattern
) (
  // Clock
  input wire logic sck,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  // Contents fixed at build time; programming lives elsewhere
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = SEED ^ 8'(i);
    end
  end

  // Registered read
  always_ff @(posedge sck) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // pbcu_secmem

/* hdl/pbcu_top.sv */
// Functional notes
// - Opcode 77h plus three dummy bytes starts a security area read out on the serial output.
// - Clocks after the last security byte give undefined output (driven as ones here).
// - Releasing chip select ends the read and floats the serial output.
// - Opcodes 53h and 55h copy a page into buffer one or two, followed by three address bytes.
// - With 528-byte pages the address holds two dummy bits, a 12-bit page, ten dummy bits.
// - With 512-byte pages the address holds three dummy bits, page from A20-A9, nine dummy bits.
// - A copy starts on the chip select rising edge and shows busy until done.
// - Opcodes 60h and 61h compare a page with buffer one or two, followed by three address bytes.
// - A compare starts on the chip select rising edge and shows busy until done.
// - At compare end the outcome is written into bit 6 of the first status byte.
// - The outcome bit is 0 on a full match and 1 when any byte differs.
// - Opcodes 58h and 59h rewrite a page in place through buffer one or two.
// - A rewrite copies the page to the buffer then programs it back, busy throughout.
// - Bit 7 of each status byte is 0 while busy and 1 when ready.
`timescale 1ns/1ps
`include "pbcu_regs.svh"
module pbcu_top import pbcu_pkg::*; #(
  parameter int unsigned COPY_CYC = `PBCU_PAGE_COPY_CYC,
  parameter int unsigned CMP_CYC = `PBCU_PAGE_COMPARE_CYC,
  parameter int unsigned REFRESH_CYC = `PBCU_PAGE_REFRESH_CYC,
  parameter int unsigned TMR_W = 20,
  parameter logic [3:0] DENSITY = `PBCU_ST_DENSITY
) (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  // Page size strap, high for 512-byte pages
  input wire logic page_512,
  // Array engine
  output logic arr_start,
  output pbcu_arr_op_e arr_op,
  output logic arr_bsel,
  output logic [`PBCU_PAGE_W-1:0] page_number_bits,
  input wire logic arr_cmp_valid,
  input wire logic arr_cmp_diff,
  // Status bytes
  output logic [7:0] status1,
  output logic [7:0] status2
);

  // Opcode decoder
  function automatic pbcu_cmd_s decode(input logic [7:0] op);
    pbcu_cmd_s c;
    c = '{valid: 1'b1, kind: KIND_COPY, bsel: 1'b0};
    case (op)
      `PBCU_OP_COPY_B1: c.kind = KIND_COPY;
      `PBCU_OP_COPY_B2: c = '{valid: 1'b1, kind: KIND_COPY, bsel: 1'b1};
      `PBCU_OP_CMP_B1: c.kind = KIND_CMP;
      `PBCU_OP_CMP_B2: c = '{valid: 1'b1, kind: KIND_CMP, bsel: 1'b1};
      `PBCU_OP_RW_B1: c.kind = KIND_RW;
      `PBCU_OP_RW_B2: c = '{valid: 1'b1, kind: KIND_RW, bsel: 1'b1};
      default: c.valid = 1'b0;
    endcase
    return c;
  endfunction

  // Page number from the address bytes, by page size
  function automatic logic [`PBCU_PAGE_W-1:0] page_of(input logic [23:0] a, input logic bin);
    return bin ? a[`PBCU_PG512_LSB +: `PBCU_PAGE_W] : a[`PBCU_PG528_LSB +: `PBCU_PAGE_W];
  endfunction

  // ---------------- Link domain (sck) ----------------
  logic [5:0] bit_cnt_reg;
  logic [31:0] cmd_sh_reg = 32'h0;
  logic cmd_tgl_reg = 1'b0;
  logic dphase_reg;
  logic [2:0] obit_reg;
  logic [7:0] byte_idx_reg;
  logic [7:0] out_sh_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic sec_hit;
  logic rd_en;
  logic [`PBCU_SEC_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic past_end;

  // Bit counter restarts with each frame; chip select high is the frame's own reset
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 6'h00;
    end else if (bit_cnt_reg != `PBCU_CMD_BITS) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  // Command shift, MSB first; left alone outside frames so the clk side can read it
  always_ff @(posedge sck) begin
    if (!cs_n && bit_cnt_reg != `PBCU_CMD_BITS) begin
      cmd_sh_reg <= {cmd_sh_reg[30:0], si};
    end
  end

  // One toggle per complete command frame, carried to clk as an event
  always_ff @(posedge sck) begin
    if (!cs_n && bit_cnt_reg == `PBCU_LAST_CMD_BIT) begin
      cmd_tgl_reg <= ~cmd_tgl_reg;
    end
  end

  // Opcode sits in bits 30:23 while the last address bit is being sampled
  assign sec_hit = (bit_cnt_reg == `PBCU_LAST_CMD_BIT) &&
                   (cmd_sh_reg[30:23] == `PBCU_OP_SEC_READ);

  // Read-out phase and its bit and byte position
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      dphase_reg <= 1'b0;
      obit_reg <= 3'h0;
      byte_idx_reg <= 8'h00;
    end else if (dphase_reg) begin
      obit_reg <= obit_reg + 3'h1;
      if (obit_reg == 3'h7 && byte_idx_reg != `PBCU_SEC_BYTES) begin
        byte_idx_reg <= byte_idx_reg + 8'h01;
      end
    end else if (sec_hit) begin
      dphase_reg <= 1'b1;
    end
  end

  // Fetch the next byte one half clock before its first bit leaves
  assign rd_en = (!cs_n && sec_hit) || (dphase_reg && obit_reg == 3'h7);
  assign rd_addr = dphase_reg ? byte_idx_reg[`PBCU_SEC_AW-1:0] + 7'h01 : 7'h00;
  assign past_end = (byte_idx_reg == `PBCU_SEC_BYTES);

  pbcu_secmem #(
    .DEPTH(128),
    .AW(`PBCU_SEC_AW)
  ) u_secmem (
    .sck(sck),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Output launched on falling sck so the host samples a settled bit on the rise
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_oe_n_reg <= 1'b1;
      so_reg <= 1'b0;
      out_sh_reg <= 8'h00;
    end else if (dphase_reg) begin
      so_oe_n_reg <= 1'b0;
      if (obit_reg == 3'h0) begin
        so_reg <= past_end ? 1'b1 : rd_data[7];
        out_sh_reg <= past_end ? 8'hFF : {rd_data[6:0], 1'b1};
      end else begin
        so_reg <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b1};
      end
    end
  end

  assign so_out = so_reg;
  assign so_oe_n = so_oe_n_reg;

  // ---------------- System domain (clk) ----------------
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic tg_s1_reg, tg_s2_reg, tg_s3_reg;
  logic pg_s1_reg, pg_s2_reg;
  logic cs_rise, cs_fall, tgl_evt;
  logic pending_reg;
  logic go_ok;
  pbcu_cmd_s cmd;
  pbcu_state_e state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic diff_acc_reg;
  logic cmp_hit;
  logic arr_start_reg;
  pbcu_arr_op_e arr_op_reg;
  logic arr_bsel_reg;
  logic [`PBCU_PAGE_W-1:0] page_reg;
  logic ready_reg;
  logic comp_reg;
  logic page_bin_reg;

  // Two-flop synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      tg_s3_reg <= 1'b0;
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      tg_s1_reg <= cmd_tgl_reg;
      tg_s2_reg <= tg_s1_reg;
      tg_s3_reg <= tg_s2_reg;
      pg_s1_reg <= page_512;
      pg_s2_reg <= pg_s1_reg;
    end
  end

  assign cs_rise = cs_s2_reg & ~cs_s3_reg;
  assign cs_fall = ~cs_s2_reg & cs_s3_reg;
  assign tgl_evt = tg_s2_reg ^ tg_s3_reg;

  // Complete frame seen; a new arrival wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else if (tgl_evt) begin
      pending_reg <= 1'b1;
    end else if (cs_rise || cs_fall) begin
      pending_reg <= 1'b0;
    end
  end

  // Opcode and address are stable while chip select is high, so read them directly.
  // A command arriving while busy is dropped rather than queued.
  assign cmd = decode(cmd_sh_reg[31:24]);
  assign go_ok = cs_rise && (pending_reg || tgl_evt) && cmd.valid && state_reg == ST_IDLE;
  assign cmp_hit = arr_cmp_valid & arr_cmp_diff;

  // Sequencer next state and timer
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go_ok) begin
          case (cmd.kind)
            KIND_COPY: begin
              state_next = ST_COPY;
              tmr_next = TMR_W'(COPY_CYC - 1);
            end
            KIND_CMP: begin
              state_next = ST_CMP;
              tmr_next = TMR_W'(CMP_CYC - 1);
            end
            default: begin
              state_next = ST_RW_COPY;
              tmr_next = TMR_W'(COPY_CYC - 1);
            end
          endcase
        end
      end
      ST_RW_COPY: begin
        if (tmr_reg == '0) begin
          state_next = ST_RW_PROG;
          tmr_next = TMR_W'(REFRESH_CYC - COPY_CYC - 1);
        end else begin
          tmr_next = tmr_reg - 1'b1;
        end
      end
      ST_COPY, ST_CMP, ST_RW_PROG: begin
        if (tmr_reg == '0) begin
          state_next = ST_IDLE;
        end else begin
          tmr_next = tmr_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        tmr_next = '0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  // Array engine request, one-cycle start pulse per phase
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_start_reg <= 1'b0;
      arr_op_reg <= ARR_COPY;
      arr_bsel_reg <= 1'b0;
      page_reg <= '0;
    end else begin
      arr_start_reg <= 1'b0;
      if (state_reg == ST_IDLE && go_ok) begin
        arr_start_reg <= 1'b1;
        arr_op_reg <= (cmd.kind == KIND_CMP) ? ARR_COMPARE : ARR_COPY;
        arr_bsel_reg <= cmd.bsel;
        page_reg <= page_of(cmd_sh_reg[23:0], pg_s2_reg);
      end else if (state_reg == ST_RW_COPY && tmr_reg == '0) begin
        arr_start_reg <= 1'b1;
        arr_op_reg <= ARR_PROGRAM;
      end
    end
  end

  // Any differing byte during the compare marks a mismatch
  always_ff @(posedge clk) begin
    if (rst) begin
      diff_acc_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      diff_acc_reg <= 1'b0;
    end else if (state_reg == ST_CMP && cmp_hit) begin
      diff_acc_reg <= 1'b1;
    end
  end

  // Status bits; outcome written only when the compare finishes
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_reg <= 1'b1;
      comp_reg <= 1'b0;
      page_bin_reg <= 1'b0;
    end else begin
      ready_reg <= (state_next == ST_IDLE);
      page_bin_reg <= pg_s2_reg;
      if (state_reg == ST_CMP && tmr_reg == '0) begin
        comp_reg <= diff_acc_reg | cmp_hit;
      end
    end
  end

  assign arr_start = arr_start_reg;
  assign arr_op = arr_op_reg;
  assign arr_bsel = arr_bsel_reg;
  assign page_number_bits = page_reg;
  assign status1 = {ready_reg, comp_reg, DENSITY, 1'b0, page_bin_reg};
  assign status2 = {ready_reg, 7'h00};

  // ---------------- Checks ----------------
  logic [TMR_W-1:0] busy_len_reg;

  // Length of the current busy period in clk cycles
  always_ff @(posedge clk) begin
    if (rst || state_reg == ST_IDLE) begin
      busy_len_reg <= '0;
    end else begin
      busy_len_reg <= busy_len_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_START_ON_CS: assert property (
    arr_start_reg && arr_op_reg != ARR_PROGRAM |-> $past(cs_rise) && $past(state_reg) == ST_IDLE
  ) else $error("array start without a chip select rise");

  AST_COPY_LEN: assert property (
    state_reg == ST_COPY && state_next == ST_IDLE |-> busy_len_reg == TMR_W'(COPY_CYC - 1)
  ) else $error("copy busy time wrong");

  AST_CMP_LEN: assert property (
    state_reg == ST_CMP && state_next == ST_IDLE |-> busy_len_reg == TMR_W'(CMP_CYC - 1)
  ) else $error("compare busy time wrong");

  AST_CMP_RESULT: assert property (
    state_reg == ST_CMP && tmr_reg == '0 |=>
      status1[`PBCU_ST_COMP_BIT] ==
        ($past(diff_acc_reg) | ($past(arr_cmp_valid) & $past(arr_cmp_diff)))
  ) else $error("compare outcome not written");

  AST_CMP_HOLD: assert property (
    state_reg != ST_CMP |=> $stable(status1[`PBCU_ST_COMP_BIT])
  ) else $error("compare bit changed outside a compare");

  AST_RW_ORDER: assert property (
    state_reg == ST_RW_COPY && tmr_reg == '0 |=>
      arr_start_reg && arr_op_reg == ARR_PROGRAM && state_reg == ST_RW_PROG ##1 !arr_start_reg
  ) else $error("rewrite program phase missing");

  AST_RW_LEN: assert property (
    state_reg == ST_RW_PROG && state_next == ST_IDLE |-> busy_len_reg == TMR_W'(REFRESH_CYC - 1)
  ) else $error("rewrite busy time wrong");

  AST_READY_BIT: assert property (
    status1[`PBCU_ST_READY_BIT] == status2[`PBCU_ST_READY_BIT] &&
      status1[`PBCU_ST_READY_BIT] == (state_reg == ST_IDLE)
  ) else $error("ready bit disagrees with sequencer");

  AST_PAGE_FIELD: assert property (
    arr_start_reg && arr_op_reg != ARR_PROGRAM |->
      page_number_bits == page_of(cmd_sh_reg[23:0], $past(pg_s2_reg))
  ) else $error("page number taken from wrong bits");

  AST_SO_HIZ: assert property (
    cs_s2_reg |-> so_oe_n
  ) else $error("serial output driven with chip select high");

  AST_SEC_START: assert property (
    @(posedge sck) disable iff (cs_n) sec_hit && !dphase_reg |=> dphase_reg
  ) else $error("security read did not start");

  AST_PAST_END: assert property (
    @(negedge sck) disable iff (cs_n) dphase_reg && past_end |=> so_out && !so_oe_n
  ) else $error("output after last security byte not as chosen");

  COV_COPY: cover property (state_reg == ST_COPY && state_next == ST_IDLE);
  COV_CMP_DIFF: cover property (state_reg == ST_CMP && tmr_reg == '0 ##1 comp_reg);
  COV_RW: cover property (state_reg == ST_RW_PROG && state_next == ST_IDLE);
  COV_SEC_READ: cover property (@(posedge sck) dphase_reg && obit_reg == 3'h7);

endmodule // pbcu_top

/* bench/pbcu_host_model.sv */
`timescale 1ns/1ps
// Host serial controller in mode 0: the clock rests low and stops between frames
module pbcu_host_model (
  // Serial link
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic [7:0] rxq[$];
  int oe_bad;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_bad = 0;
  end

  // Shift nbits of w out, then clock nrd bytes back; bits past the command are junk
  task automatic frame(input logic [31:0] w, input int nbits, input int nrd);
    logic [7:0] b;
    b = 8'h00;
    rxq.delete();
    cs_n = 1'b0;
    for (int i = 0; i < nbits + 8 * nrd; i++) begin
      if (i < nbits) si = w[31-i];
      else si = ~si;
      #62.5;
      if (i >= nbits) begin
        b = {b[6:0], so_out};
        if (so_oe_n !== 1'b0) oe_bad++;
        if ((i - nbits) % 8 == 7) rxq.push_back(b);
      end
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #62.5;
    cs_n = 1'b1;
    // A released line flips so a stale bit never looks valid
    si = ~si;
    #500;
  endtask
endmodule // pbcu_host_model

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "pbcu_regs.svh"
module testbench import pbcu_pkg::*;;
  // Short busy times keep the run brief; the rewrite outlasts a whole frame
  localparam int CPY = 8;
  localparam int CMPC = 8;
  localparam int RFR = 120;
  logic clk, rst, sck, cs_n, si, so_out, so_oe_n, page_512, arr_start, arr_bsel;
  logic arr_cmp_valid, arr_cmp_diff, acc, in_cmp, exp_comp;
  logic [1:0] diffy;
  pbcu_arr_op_e arr_op;
  logic [11:0] page_number_bits;
  logic [7:0] status1, status2;
  logic [14:0] st_q[$];
  logic [7:0] ops[6] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
  int errors, total_checks, bcnt, last_busy, done_cnt, rdy_bad;

  pbcu_top #(.COPY_CYC(CPY), .CMP_CYC(CMPC), .REFRESH_CYC(RFR)) pbcu_top_i (
    .clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out),
    .so_oe_n(so_oe_n), .page_512(page_512), .arr_start(arr_start), .arr_op(arr_op),
    .arr_bsel(arr_bsel), .page_number_bits(page_number_bits),
    .arr_cmp_valid(arr_cmp_valid), .arr_cmp_diff(arr_cmp_diff),
    .status1(status1), .status2(status2)
  );
  pbcu_host_model pbcu_host_model_i (
    .sck(sck), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe_n(so_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Log start pulses and busy spans as the design shows them
  always @(posedge clk) begin
    if (!rst) begin
      if (arr_start === 1'b1) st_q.push_back({arr_op, arr_bsel, page_number_bits});
      if (arr_cmp_valid && arr_cmp_diff) acc = 1'b1;
      if (status1[7] !== status2[7]) rdy_bad++;
      if (status1[7] === 1'b0) bcnt++;
      else if (bcnt != 0) begin
        last_busy = bcnt;
        bcnt = 0;
        done_cnt++;
      end
    end
  end

  // Byte results only mid-compare, so edge cycles never decide the outcome
  always @(posedge clk) begin
    arr_cmp_valid <= in_cmp && bcnt > 1 && bcnt < CMPC - 2;
    arr_cmp_diff <= diffy[1] | (diffy[0] & (($urandom % 2) == 1));
  end

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cyc(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic int exp_len(input logic [7:0] op);
    return (op[7:4] == 4'h6) ? CMPC : (op[3] ? RFR : CPY);
  endfunction

  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One internal command; intr sends a copy while the first is still busy
  task automatic run_op(input logic [7:0] op, input logic [23:0] a, input logic [1:0] dfy,
                        input logic intr);
    int d0;
    logic [11:0] pg;
    logic bs;
    logic cmp;
    pbcu_arr_op_e eop;
    d0 = done_cnt;
    acc = 1'b0;
    st_q.delete();
    diffy = dfy;
    cmp = (op[7:4] == 4'h6);
    bs = (op == 8'h55) || (op == 8'h61) || (op == 8'h59);
    eop = cmp ? ARR_COMPARE : ARR_COPY;
    pg = page_512 ? a[20:9] : a[21:10];
    in_cmp = cmp;
    pbcu_host_model_i.frame({op, a}, 32, 0);
    if (intr) pbcu_host_model_i.frame({8'h53, a}, 32, 0);
    for (int n = 0; n < 400 && done_cnt == d0; n++) @(posedge clk);
    in_cmp = 1'b0;
    @(posedge clk);
    chk_cyc("busy ends", 1, done_cnt - d0);
    if (cmp) exp_comp = acc;
    chk_cyc("busy cycles", exp_len(op), last_busy);
    chk_cyc("start pulses", op[3] ? 2 : 1, st_q.size());
    if (st_q.size() > 0) chk_val("first start", {eop, bs, pg}, st_q[0]);
    if (st_q.size() > 1) chk_val("second start", {ARR_PROGRAM, bs, pg}, st_q[1]);
    chk_val("status1", {1'b1, exp_comp, 4'hB, 1'b0, page_512}, status1);
    chk_val("status2", 8'h80, status2);
  endtask

  initial begin
    #5000000;
    errors++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    page_512 = 1'b0;
    diffy = 2'b00;
    in_cmp = 1'b0;
    acc = 1'b0;
    exp_comp = 1'b0;
    errors = 0;
    total_checks = 0;
    bcnt = 0;
    last_busy = 0;
    done_cnt = 0;
    rdy_bad = 0;
    void'($urandom(51));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk_val("status1 reset", 8'hAC, status1);
    chk_val("so idle", 2'b10, {so_oe_n, so_out});
    // Every internal command opcode in both page sizes, random page and dummy bits
    for (int m = 0; m < 2; m++) begin
      page_512 <= m[0];
      repeat (5) @(posedge clk);
      foreach (ops[i]) run_op(ops[i], 24'($urandom), 2'($urandom % 2), 1'b0);
    end
    // Boundary pages; a differing compare then a matching one
    run_op(8'h60, 24'hFFFFFF, 2'b10, 1'b0);
    run_op(8'h61, 24'h000000, 2'b00, 1'b0);
    // A copy sent mid-rewrite must be dropped; every rewrite refreshes its page
    run_op(8'h59, 24'($urandom), 2'b00, 1'b1);
    // Short frame and unknown opcode start nothing
    st_q.delete();
    pbcu_host_model_i.frame(32'h53FFFFFF, 20, 0);
    pbcu_host_model_i.frame(32'hA5000000, 32, 0);
    repeat (20) @(posedge clk);
    chk_cyc("refused starts", 0, st_q.size());
    // Aborted read, then a full read past the end of the area
    pbcu_host_model_i.frame({8'h77, 24'($urandom)}, 32, 2);
    chk_val("so released", 2'b10, {so_oe_n, so_out});
    pbcu_host_model_i.frame({8'h77, 24'($urandom)}, 32, 130);
    for (int i = 0; i < 130; i++) begin
      chk_val("security byte", (i < 128) ? (8'h5A ^ i[7:0]) : 8'hFF, pbcu_host_model_i.rxq[i]);
    end
    chk_cyc("so enable during read", 0, pbcu_host_model_i.oe_bad);
    chk_val("so after read", 2'b10, {so_oe_n, so_out});
    chk_cyc("ready bits differ", 0, rdy_bad);
    conclude();
  end
endmodule // testbench
